// *** fdw_pkg.sv ***
// Purpose: shared constants and types of the data memory / flash write block
// Assumes: 100 MHz hclk, 32-bit AHB-Lite register window
// Notes:   all offsets, bit positions, reset values and timing counts live here
package fdw_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] MEMCTL_OFS = 8'h00;
  localparam logic [7:0] AUXCTL_OFS = 8'h04;
  localparam logic [7:0] PSW_OFS    = 8'h08;
  // memory_control_reg bits
  localparam int IAP_BIT   = 7;
  localparam int AUTO_PAGE_ERASE_BIT  = 6;
  localparam int PAGE_BUFFER_LOAD_BIT  = 5;
  localparam int NV_WRITE_ENABLE_BIT  = 4;
  localparam int DATA_FLASH_ENABLE_BIT  = 3;
  localparam int ERR_BIT   = 2;
  localparam int BUSY_BIT  = 1;
  localparam int WINH_BIT  = 0;
  // auxiliary_control_reg and processor_status_word bits
  localparam int FEXT_BIT  = 1;
  localparam int BANK_LO   = 3;
  localparam logic [4:0] MEMCTL_RST = 5'h00;
  localparam logic [1:0] BANK_RST   = 2'h0;
  // ************************************************************
  // memory geometry
  // ************************************************************
  localparam int BUF_BYTES  = 64;
  localparam int PAGE_BYTES = 128;
  localparam int FL_BYTES   = 256;
  localparam logic [7:0] SFR_BASE  = 8'h80;
  localparam logic [3:0] BIT_BASE  = 4'h2;
  localparam logic [7:0] ERASED    = 8'hFF;
  localparam logic [15:0] FL_TOP   = 16'h0100;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ       = 100;
  localparam int ERASE_TIME_US = 2000;
  localparam int PROG_TIME_US  = 2000;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int PROG_CYC  = PROG_TIME_US * CLK_MHZ;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b10
  } fdw_state_e;
  typedef enum logic [2:0] {
    K_DIRECT   = 3'b000,
    K_REG      = 3'b001,
    K_BIT      = 3'b010,
    K_INDIRECT = 3'b011,
    K_EXT16    = 3'b100,
    K_EXT8     = 3'b101
  } fdw_kind_e;
endpackage

// *** fdw_nvm_if.sv ***
// Purpose: carrier between the sequencer, page buffer and flash array
// Assumes: one clock domain
// Notes:   buffer contents are visible to the array as whole vectors
`timescale 1ns/10ps
interface fdw_nvm_if;
  logic       buf_wr;
  logic [5:0] buf_idx;
  logic [7:0] buf_wdata;
  logic       buf_clr;
  logic [7:0] buf_data [64];
  logic [63:0] buf_vld;
  logic       erase;
  logic       prog;
  logic       page;
  logic       half;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output buf_wr, buf_idx, buf_wdata, buf_clr, erase, prog,
                page, half, rd_addr, input buf_vld, rd_data);
  modport pbuf (input buf_wr, buf_idx, buf_wdata, buf_clr,
                output buf_data, buf_vld);
  modport arr  (input buf_data, buf_vld, erase, prog, page, half, rd_addr,
                output rd_data);
endinterface

// *** fdw_page_buffer.sv ***
// Purpose: half-page load buffer with per-byte valid marks
// Assumes: single writer, clear has priority over load
// Notes:   data bytes carry no reset, only the valid marks do
`timescale 1ns/10ps
module fdw_page_buffer (
  input  wire logic hclk,     // system clock
  input  wire logic hresetn,  // async reset, active low
  fdw_nvm_if.pbuf   nvm       // buffer side of the carrier
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm.buf_vld <= 64'h0;
    end else if (nvm.buf_clr) begin
      nvm.buf_vld <= 64'h0;
    end else if (nvm.buf_wr) begin
      nvm.buf_vld[nvm.buf_idx] <= 1'b1;
    end
  end

  always_ff @(posedge hclk) begin
    if (nvm.buf_wr) begin
      nvm.buf_data[nvm.buf_idx] <= nvm.buf_wdata;
    end
  end
endmodule

// *** fdw_flash_array.sv ***
// Purpose: 256-byte flash data array, two 128-byte pages
// Assumes: erase and program strobes are one-cycle pulses, never together
// Notes:   contents are unknown until erased, as in a fresh part
`timescale 1ns/10ps
module fdw_flash_array (
  input  wire logic hclk,  // system clock
  fdw_nvm_if.arr    nvm    // array side of the carrier
);
  logic [7:0] mem [fdw_pkg::FL_BYTES];

  assign nvm.rd_data = mem[nvm.rd_addr];

  always_ff @(posedge hclk) begin
    if (nvm.erase) begin
      for (int i = 0; i < fdw_pkg::PAGE_BYTES; i++) begin
        mem[{nvm.page, 7'(i)}] <= fdw_pkg::ERASED;
      end
    end else if (nvm.prog) begin
      for (int i = 0; i < fdw_pkg::BUF_BYTES; i++) begin
        if (nvm.buf_vld[i]) begin
          // programming can only pull ones down to zero
          mem[{nvm.page, nvm.half, 6'(i)}] <=
            mem[{nvm.page, nvm.half, 6'(i)}] & nvm.buf_data[i];
        end
      end
    end
  end
endmodule

// *** fdw_top.sv ***
// Purpose: internal RAM decode, external data routing, flash data writes
// Assumes: core accesses are one-cycle requests; registers over AHB-Lite
// Notes:   zero-wait AHB slave; core stalls only in idle-while-write
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - direct addresses below 80H reach the first 128 RAM bytes
// - lowest 32 bytes form four banks of eight; two status bits pick one
// - bit addresses 00H-7FH map onto RAM bytes 20H-2FH
// - all 256 RAM bytes reachable indirectly; stack lives there too
// - direct 80H-FFH go to special function space; indirect goes to RAM
// - 16-bit external space reached by 16-bit or 8-bit pointer moves
// - internally mapped low external addresses served inside; rest external
// - force-external bit sends every external move outside
// - flash data at 0000H-00FFH only when enabled and app-program select clear
// - flash data only via 16-bit pointer; 8-bit pointer goes external
// - internal-code write idles the core, defers interrupts, then resumes
// - external-code write keeps core running; software polls busy
// - flash writes accepted only with write enable and flash enable set
// - programming only clears bits; ones leave stored bits unchanged
// - erase sets every byte of the page to FFH
// - two 128-byte pages, 64-byte buffer, at most 64 bytes per write
// - full page needs two writes, low half then high half
// - with page load set writes only fill the buffer; no reloads
// - with page load clear the next write adds its byte and starts
// - buffer cleared after every finished write
// - auto-erase erases whole page first, then programs one half
// - no write sequence starts while brown-out reports low supply
// - brown-out during a write sets a sticky error flag
module fdw_top #(
  parameter int ERASE_CYC = fdw_pkg::ERASE_CYC,  // erase length in cycles
  parameter int PROG_CYC  = fdw_pkg::PROG_CYC    // program length in cycles
) (
  input  wire logic        hclk,          // system clock
  input  wire logic        hresetn,       // async reset, active low
  input  wire logic        hsel,          // ahb slave select
  input  wire logic [31:0] haddr,         // ahb address
  input  wire logic [1:0]  htrans,        // ahb transfer type
  input  wire logic        hwrite,        // ahb write
  input  wire logic [2:0]  hsize,         // ahb size
  input  wire logic [31:0] hwdata,        // ahb write data
  input  wire logic        hready,        // ahb bus ready
  output logic             hreadyout,     // ahb slave ready
  output logic             hresp,         // ahb response
  output logic [31:0]      hrdata,        // ahb read data
  input  wire logic        acc_valid,     // core access request
  output logic             acc_ready,     // core access taken
  input  wire logic [2:0]  acc_kind,      // addressing kind
  input  wire logic [15:0] acc_addr,      // access address
  input  wire logic        acc_write,     // access is a write
  input  wire logic [7:0]  acc_wdata,     // write data, bit in [0]
  input  wire logic        exec_internal, // core runs internal code
  input  wire logic        bod_low,       // brown-out low supply
  output logic             rsp_valid,     // ram or flash read data valid
  output logic [7:0]       rsp_data,      // ram or flash read data
  output logic             sfr_req,       // special function access
  output logic             ext_req,       // external memory access
  output logic [15:0]      out_addr,      // sfr or external address
  output logic             out_write,     // sfr or external write
  output logic [7:0]       out_wdata,     // sfr or external write data
  output logic             core_stall,    // core idled by flash write
  output logic             irq_hold       // interrupt service deferred
);
  // ************************************************************
  // registers and state
  // ************************************************************
  logic [7:0]  ram [256];
  logic [4:0]  memctl;
  logic        err;
  logic        force_external_ram;
  logic [1:0]  bank_sel;
  logic        wr_internal;
  logic [31:0] cnt;
  logic        dph_wr;
  logic [7:0]  dph_addr;
  fdw_pkg::fdw_state_e state;
  fdw_pkg::fdw_kind_e  kind;
  fdw_nvm_if nvm ();

  logic in_app_program_select;
  logic auto_page_erase;
  logic page_buffer_load;
  logic nv_write_enable;
  logic data_flash_enable;
  logic busy;
  logic take;
  logic to_ram;
  logic to_sfr;
  logic to_fl;
  logic is_bit;
  logic [7:0] ram_a;
  logic [2:0] bit_n;
  logic fl_wr;
  logic accept;
  logic start;
  logic err_clr;

  assign in_app_program_select = memctl[4];
  assign auto_page_erase       = memctl[3];
  assign page_buffer_load      = memctl[2];
  assign nv_write_enable       = memctl[1];
  assign data_flash_enable     = memctl[0];
  assign busy = (state != fdw_pkg::ST_IDLE);
  assign kind = fdw_pkg::fdw_kind_e'(acc_kind);

  fdw_page_buffer u_buf (
    .hclk    (hclk),
    .hresetn (hresetn),
    .nvm     (nvm)
  );

  fdw_flash_array u_arr (
    .hclk (hclk),
    .nvm  (nvm)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  always_comb begin
    to_ram = 1'b0;
    to_sfr = 1'b0;
    to_fl  = 1'b0;
    is_bit = 1'b0;
    ram_a  = acc_addr[7:0];
    bit_n  = acc_addr[2:0];
    unique case (kind)
      fdw_pkg::K_DIRECT: begin
        to_ram = (acc_addr[7:0] < fdw_pkg::SFR_BASE);
        to_sfr = !to_ram;
      end
      fdw_pkg::K_REG: begin
        to_ram = 1'b1;
        ram_a  = {3'b000, bank_sel, acc_addr[2:0]};
      end
      fdw_pkg::K_BIT: begin
        is_bit = 1'b1;
        to_ram = !acc_addr[7];
        to_sfr = acc_addr[7];
        ram_a  = {fdw_pkg::BIT_BASE, acc_addr[6:3]};
      end
      fdw_pkg::K_INDIRECT: begin
        to_ram = 1'b1;
      end
      fdw_pkg::K_EXT16: begin
        // forcing external overrides every internal mapping
        to_fl = !force_external_ram && data_flash_enable
                && !in_app_program_select && (acc_addr < fdw_pkg::FL_TOP);
      end
      fdw_pkg::K_EXT8: begin
        to_fl = 1'b0;
      end
      default: begin
        to_ram = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // core access path
  // ************************************************************
  assign core_stall = busy && wr_internal;
  assign irq_hold   = core_stall;
  assign acc_ready  = !core_stall;
  assign take       = acc_valid && acc_ready;

  always_ff @(posedge hclk) begin
    if (take && to_ram && acc_write) begin
      if (is_bit) begin
        ram[ram_a][bit_n] <= acc_wdata[0];
      end else begin
        ram[ram_a] <= acc_wdata;
      end
    end
  end

  assign nvm.rd_addr = acc_addr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      rsp_valid <= take && !acc_write && (to_ram || to_fl);
      if (take && to_ram) begin
        rsp_data <= is_bit ? {7'h00, ram[ram_a][bit_n]} : ram[ram_a];
      end else if (take && to_fl) begin
        rsp_data <= nvm.rd_data;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sfr_req   <= 1'b0;
      ext_req   <= 1'b0;
      out_addr  <= 16'h0000;
      out_write <= 1'b0;
      out_wdata <= 8'h00;
    end else begin
      sfr_req <= take && to_sfr;
      ext_req <= take && !to_fl && (kind == fdw_pkg::K_EXT16
                 || kind == fdw_pkg::K_EXT8);
      if (take) begin
        out_addr  <= is_bit ? {8'h00, acc_addr[7:3], 3'b000} : acc_addr;
        out_write <= acc_write;
        out_wdata <= acc_wdata;
      end
    end
  end

  // ************************************************************
  // flash write sequencer
  // ************************************************************
  assign fl_wr  = take && to_fl && acc_write
                  && nv_write_enable && data_flash_enable;
  // writes while busy are dropped; a second sequence cannot overlap
  assign accept = fl_wr && !busy && !bod_low;
  assign start  = accept && !page_buffer_load;
  assign nvm.buf_wr    = accept;
  assign nvm.buf_idx   = acc_addr[5:0];
  assign nvm.buf_wdata = acc_wdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= fdw_pkg::ST_IDLE;
      cnt         <= 32'h0;
      wr_internal <= 1'b0;
      nvm.page    <= 1'b0;
      nvm.half    <= 1'b0;
    end else if (busy && bod_low) begin
      state <= fdw_pkg::ST_IDLE;
    end else begin
      unique case (state)
        fdw_pkg::ST_IDLE: begin
          if (start) begin
            wr_internal <= exec_internal;
            nvm.page    <= acc_addr[7];
            nvm.half    <= acc_addr[6];
            if (auto_page_erase) begin
              state <= fdw_pkg::ST_ERASE;
              cnt   <= 32'(ERASE_CYC - 1);
            end else begin
              state <= fdw_pkg::ST_PROG;
              cnt   <= 32'(PROG_CYC - 1);
            end
          end
        end
        fdw_pkg::ST_ERASE: begin
          if (cnt == 32'h0) begin
            state <= fdw_pkg::ST_PROG;
            cnt   <= 32'(PROG_CYC - 1);
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        fdw_pkg::ST_PROG: begin
          if (cnt == 32'h0) begin
            state <= fdw_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: begin
          state <= fdw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign nvm.erase = (state == fdw_pkg::ST_ERASE) && (cnt == 32'h0) && !bod_low;
  assign nvm.prog  = (state == fdw_pkg::ST_PROG) && (cnt == 32'h0) && !bod_low;
  assign nvm.buf_clr = nvm.prog || (busy && bod_low);

  // ************************************************************
  // ahb-lite register slave
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign err_clr   = dph_wr && dph_addr == fdw_pkg::MEMCTL_OFS
                     && !hwdata[fdw_pkg::ERR_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr   <= 1'b0;
      dph_addr <= 8'h00;
      hrdata   <= 32'h0;
    end else begin
      dph_wr <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        dph_wr   <= hwrite;
        dph_addr <= haddr[7:0];
        hrdata   <= 32'h0;
        if (haddr[7:0] == fdw_pkg::MEMCTL_OFS) begin
          hrdata[7:0] <= {memctl, err, busy, !bod_low};
        end else if (haddr[7:0] == fdw_pkg::AUXCTL_OFS) begin
          hrdata[fdw_pkg::FEXT_BIT] <= force_external_ram;
        end else if (haddr[7:0] == fdw_pkg::PSW_OFS) begin
          hrdata[fdw_pkg::BANK_LO +: 2] <= bank_sel;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      memctl             <= fdw_pkg::MEMCTL_RST;
      force_external_ram <= 1'b0;
      bank_sel           <= fdw_pkg::BANK_RST;
    end else if (dph_wr) begin
      if (dph_addr == fdw_pkg::MEMCTL_OFS) begin
        memctl <= hwdata[fdw_pkg::IAP_BIT:fdw_pkg::DATA_FLASH_ENABLE_BIT];
      end
      if (dph_addr == fdw_pkg::AUXCTL_OFS) begin
        force_external_ram <= hwdata[fdw_pkg::FEXT_BIT];
      end
      if (dph_addr == fdw_pkg::PSW_OFS) begin
        bank_sel <= hwdata[fdw_pkg::BANK_LO +: 2];
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err <= 1'b0;
    end else if (busy && bod_low) begin
      err <= 1'b1;
    end else if (err_clr) begin
      err <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_start;
    start && !bod_low;
  endsequence
  sequence s_hold_busy;
    busy [*2];
  endsequence

  chk_direct_ram: assert property (
    kind == fdw_pkg::K_DIRECT && !acc_addr[7] |-> to_ram && ram_a == acc_addr[7:0])
    else $error("low direct address not routed to ram");
  chk_sfr_route: assert property (
    take && kind == fdw_pkg::K_DIRECT && acc_addr[7] |=> sfr_req && !ext_req)
    else $error("upper direct address missed special function space");
  chk_ext8_out: assert property (
    take && kind == fdw_pkg::K_EXT8 |=> ext_req && !rsp_valid)
    else $error("8-bit pointer move not sent outside");
  chk_force_ext: assert property (
    take && force_external_ram && kind == fdw_pkg::K_EXT16 |=> ext_req)
    else $error("forced external move served inside");
  chk_busy_start: assert property (
    s_start |=> s_hold_busy)
    else $error("busy not held after write start");
  chk_stall_int: assert property (
    (s_start and exec_internal) |=> !acc_ready && irq_hold)
    else $error("internal-code write did not idle the core");
  chk_run_ext: assert property (
    (s_start and !exec_internal) |=> acc_ready && busy)
    else $error("external-code write stalled the core");
  chk_bod_refuse: assert property (
    fl_wr && bod_low && !busy |=> !busy && $stable(nvm.buf_vld))
    else $error("write sequence began under brown-out");
  chk_err_sticky: assert property (
    busy && bod_low |=> err ##1 (err || $past(err_clr)))
    else $error("brown-out error flag not kept");
  chk_no_enable: assert property (
    take && to_fl && acc_write && !nv_write_enable
      |=> $past(busy) || (!busy && $stable(nvm.buf_vld)))
    else $error("flash write taken without write enable");
endmodule

// *** fdw_core_model.sv ***
// Purpose: core-side model that issues byte accesses into the block
// Assumes: one request at a time, launched just after a rising edge
// Notes:   res 1 ram or flash data, 2 special space, 3 external, 0 none
`timescale 1ns/10ps
module fdw_core_model (
  input  wire logic        hclk,       // system clock
  output logic             acc_valid,  // request
  input  wire logic        acc_ready,  // request taken
  output logic [2:0]       acc_kind,   // addressing kind
  output logic [15:0]      acc_addr,   // address
  output logic             acc_write,  // write
  output logic [7:0]       acc_wdata,  // write data
  input  wire logic        rsp_valid,  // ram or flash data pulse
  input  wire logic [7:0]  rsp_data,   // read data
  input  wire logic        sfr_req,    // special space pulse
  input  wire logic        ext_req     // external pulse
);
  logic [1:0] res;
  logic [7:0] rdat;
  initial begin
    acc_valid = 1'b0;
    acc_kind  = 3'h0;
    acc_addr  = 16'h0000;
    acc_write = 1'b0;
    acc_wdata = 8'h00;
  end
  task automatic acc(input logic [2:0] k, input logic [15:0] a,
                     input logic w, input logic [7:0] d);
    @(posedge hclk);
    acc_valid <= 1'b1;
    acc_kind  <= k;
    acc_addr  <= a;
    acc_write <= w;
    acc_wdata <= d;
    // a stalled core just keeps asking until the write ends
    do @(posedge hclk); while (!acc_ready);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_wdata <= ~d;
    #1;
    res  = rsp_valid ? 2'h1 : sfr_req ? 2'h2 : ext_req ? 2'h3 : 2'h0;
    rdat = rsp_valid ? rsp_data : 8'h00;
  endtask
endmodule

// *** test_data_memory_flash_write_ctrl.sv ***
// Purpose: self-checking bench for data decode and flash data writes
// Assumes: short erase and program counts, bench drives the ahb side
// Notes:   page 0 is erased before any flash contents are compared
`timescale 1ns/10ps
module test_data_memory_flash_write_ctrl;
  localparam int ECYC = 20;
  localparam int PCYC = 20;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, acc_kind;
  logic        acc_valid, acc_ready, acc_write, exec_internal, bod_low;
  logic [15:0] acc_addr, out_addr;
  logic [7:0]  acc_wdata, rsp_data, out_wdata;
  logic        rsp_valid, sfr_req, ext_req, out_write, core_stall, irq_hold;
  int          n_mismatch = 0;
  int          num_checks = 0;
  assign hready = hreadyout;
  fdw_top #(.ERASE_CYC(ECYC), .PROG_CYC(PCYC)) i_fdw_top (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .acc_valid, .acc_ready, .acc_kind, .acc_addr, .acc_write,
    .acc_wdata, .exec_internal, .bod_low, .rsp_valid, .rsp_data, .sfr_req,
    .ext_req, .out_addr, .out_write, .out_wdata, .core_stall, .irq_hold);
  fdw_core_model i_fdw_core_model (.hclk, .acc_valid, .acc_ready, .acc_kind,
    .acc_addr, .acc_write, .acc_wdata, .rsp_valid, .rsp_data, .sfr_req,
    .ext_req);
  always #5 hclk = ~hclk;
  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge hclk); while (!hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h00000000, r);
    chk(nm, e, r & m);
  endtask
  task automatic cw(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
    i_fdw_core_model.acc(k, a, 1'b1, d);
  endtask
  task automatic cx(input string nm, input logic [2:0] k, input logic [15:0] a,
                    input logic [1:0] er, input logic [7:0] ed);
    i_fdw_core_model.acc(k, a, 1'b0, 8'h00);
    chk(nm, {22'h000000, er, ed},
        {22'h000000, i_fdw_core_model.res, i_fdw_core_model.rdat});
  endtask
  task automatic idle;
    logic [31:0] r;
    r = 32'h00000002;
    for (int i = 0; i < 500 && r[1]; i++) ahb(1'b0, fdw_pkg::MEMCTL_OFS, 32'h0, r);
    chk("busy_clear", 32'h0, r & 32'h00000002);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch++;
    test_done;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    exec_internal = 1'b0;
    bod_low = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("memctl_rst", fdw_pkg::MEMCTL_OFS, 32'hFF, 32'h01);
    rdc("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h0);
    cw(fdw_pkg::K_DIRECT, 16'h0010, 8'hA5);
    cx("direct_ram", fdw_pkg::K_INDIRECT, 16'h0010, 2'h1, 8'hA5);
    cx("direct_sfr", fdw_pkg::K_DIRECT, 16'h0090, 2'h2, 8'h00);
    cw(fdw_pkg::K_BIT, 16'h0093, 8'h01);
    chk("bit_sfr_out", {4'h0, 2'h2, 2'h1, 16'h0090, 8'h01},
        {4'h0, i_fdw_core_model.res, hresp, out_write, out_addr, out_wdata});
    cw(fdw_pkg::K_INDIRECT, 16'h0090, 8'h5C);
    cx("indirect_hi", fdw_pkg::K_INDIRECT, 16'h0090, 2'h1, 8'h5C);
    wr(fdw_pkg::PSW_OFS, 32'h10);
    cw(fdw_pkg::K_REG, 16'h0003, 8'h5A);
    cx("bank2_r3", fdw_pkg::K_DIRECT, 16'h0013, 2'h1, 8'h5A);
    cw(fdw_pkg::K_DIRECT, 16'h0021, 8'h00);
    cw(fdw_pkg::K_BIT, 16'h000A, 8'h01);
    cx("bit_0a", fdw_pkg::K_DIRECT, 16'h0021, 2'h1, 8'h04);
    cx("ext_high", fdw_pkg::K_EXT16, 16'h0200, 2'h3, 8'h00);
    cx("flash_off", fdw_pkg::K_EXT16, 16'h0010, 2'h3, 8'h00);
    wr(fdw_pkg::MEMCTL_OFS, 32'h08);
    cx("ptr8_ext", fdw_pkg::K_EXT8, 16'h0010, 2'h3, 8'h00);
    wr(fdw_pkg::AUXCTL_OFS, 32'h02);
    cx("force_ext", fdw_pkg::K_EXT16, 16'h0010, 2'h3, 8'h00);
    wr(fdw_pkg::AUXCTL_OFS, 32'h00);
    wr(fdw_pkg::MEMCTL_OFS, 32'h88);
    cx("app_sel", fdw_pkg::K_EXT16, 16'h0010, 2'h3, 8'h00);
    // external code: core keeps running, interrupt service is not deferred
    wr(fdw_pkg::MEMCTL_OFS, 32'h58);
    cw(fdw_pkg::K_EXT16, 16'h0005, 8'h3C);
    chk("no_stall", 32'h0, {30'h0, core_stall, irq_hold});
    rdc("busy_set", fdw_pkg::MEMCTL_OFS, 32'h02, 32'h02);
    idle;
    cx("erase_hi", fdw_pkg::K_EXT16, 16'h0070, 2'h1, 8'hFF);
    cx("prog_byte", fdw_pkg::K_EXT16, 16'h0005, 2'h1, 8'h3C);
    wr(fdw_pkg::MEMCTL_OFS, 32'h18);
    cw(fdw_pkg::K_EXT16, 16'h0005, 8'hF0);
    idle;
    cx("and_only", fdw_pkg::K_EXT16, 16'h0005, 2'h1, 8'h30);
    wr(fdw_pkg::MEMCTL_OFS, 32'h08);
    cw(fdw_pkg::K_EXT16, 16'h0007, 8'h00);
    rdc("no_we_idle", fdw_pkg::MEMCTL_OFS, 32'h02, 32'h0);
    cx("no_we", fdw_pkg::K_EXT16, 16'h0007, 2'h1, 8'hFF);
    // each buffer slot loaded once only
    wr(fdw_pkg::MEMCTL_OFS, 32'h38);
    cw(fdw_pkg::K_EXT16, 16'h0041, 8'h11);
    cw(fdw_pkg::K_EXT16, 16'h0042, 8'h22);
    cx("load_only", fdw_pkg::K_EXT16, 16'h0041, 2'h1, 8'hFF);
    wr(fdw_pkg::MEMCTL_OFS, 32'h18);
    exec_internal <= 1'b1;
    cw(fdw_pkg::K_EXT16, 16'h0043, 8'h33);
    chk("stall", 32'h3, {30'h0, core_stall, irq_hold});
    for (int i = 1; i < 4; i++) begin
      cx("half_page", fdw_pkg::K_EXT16, 16'h0040 + 16'(i), 2'h1, 8'(8'h11 * i));
    end
    exec_internal <= 1'b0;
    // stale slots 1..3 would land in the low half if kept
    cw(fdw_pkg::K_EXT16, 16'h0005, 8'h30);
    idle;
    cx("buf_clear", fdw_pkg::K_EXT16, 16'h0001, 2'h1, 8'hFF);
    bod_low <= 1'b1;
    cw(fdw_pkg::K_EXT16, 16'h0008, 8'h00);
    rdc("bod_block", fdw_pkg::MEMCTL_OFS, 32'h07, 32'h0);
    cx("bod_noprog", fdw_pkg::K_EXT16, 16'h0008, 2'h1, 8'hFF);
    bod_low <= 1'b0;
    wr(fdw_pkg::MEMCTL_OFS, 32'h58);
    cw(fdw_pkg::K_EXT16, 16'h0009, 8'h00);
    repeat (3) @(posedge hclk);
    bod_low <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc("bod_err", fdw_pkg::MEMCTL_OFS, 32'h07, 32'h04);
    bod_low <= 1'b0;
    rdc("err_sticky", fdw_pkg::MEMCTL_OFS, 32'h04, 32'h04);
    wr(fdw_pkg::MEMCTL_OFS, 32'h18);
    rdc("err_clear", fdw_pkg::MEMCTL_OFS, 32'h04, 32'h0);
    test_done;
  end
endmodule
